// file: core/icir_pkg.sv
// Package for the isochronous context interrupt register block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package icir_pkg;
	localparam int ICIR_TX_N = 8;
	localparam int ICIR_RX_N = 4;
	localparam logic [7:0] ICIR_TX_EVENT_SET = 8'h90;
	localparam logic [7:0] ICIR_TX_EVENT_CLEAR = 8'h94;
	localparam logic [7:0] ICIR_TX_MASK_SET = 8'h98;
	localparam logic [7:0] ICIR_TX_MASK_CLEAR = 8'h9C;
	localparam logic [7:0] ICIR_RX_EVENT_SET = 8'hA0;
	localparam logic [7:0] ICIR_RX_EVENT_CLEAR = 8'hA4;
	localparam logic [7:0] ICIR_RX_MASK_SET = 8'hA8;
	localparam logic [7:0] ICIR_RX_MASK_CLEAR = 8'hAC;
	localparam logic [7:0] ICIR_MAIN_EVENT = 8'hB0;
	localparam logic [7:0] ICIR_MAIN_MASK_SET = 8'hB4;
	localparam logic [7:0] ICIR_MAIN_MASK_CLEAR = 8'hB8;
	localparam int ICIR_TX_SUM_BIT = 6;
	localparam int ICIR_RX_SUM_BIT = 7;
	localparam int ICIR_GLOBAL_EN_BIT = 31;
	localparam logic [7:0] ICIR_TX_RESET = 8'h00;
	localparam logic [3:0] ICIR_RX_RESET = 4'h0;
endpackage : icir_pkg

// file: core/icir_regs.sv
// Per-context isochronous interrupt event and mask registers.
// Assumes a classic Wishbone master on CLOCK; context pulses synchronous.
//
// Contract
// RQ1 - Transmit bit latches when last-output command completes with interrupt.
// RQ2 - Receive bit latches when any input command completes with interrupt.
// RQ3 - Transmit bit sets on rising context edge or written one at 90h.
// RQ4 - Receive bit sets on rising context edge or written one at A0h.
// RQ5 - Only writing one at clear address clears an event bit.
// RQ6 - Reading 94h returns transmit events ANDed with transmit mask.
// RQ7 - Reading A4h returns receive events ANDed with receive mask.
// RQ8 - Transmit bits 7..0 belong to transmit contexts of same index.
// RQ9 - Transmit event bits 31..8 read zero and ignore writes.
// RQ10 - Receive bits 3..0 implemented; bits above read zero, ignore writes.
// RQ11 - Any transmit event drives summary bit six of main event; code ORs only events whose transmit mask bit is set.
// RQ12 - Any receive event drives summary bit seven of main event; code ORs only events whose receive mask bit is set.
// RQ13 - Transmit mask: one sets at 98h, one clears at 9Ch.
// RQ14 - Reads of 98h or 9Ch return the transmit mask.
// RQ15 - Transmit mask bits align with event bits; only 7..0 writable.
// RQ16 - Software reads context events, then writes ones to clear them.
// RQ17 - No interrupt unless global enable bit is one.
// RQ18 - Transmit summary interrupts only with main mask bit six set.
// RQ19 - Receive summary interrupts only with main mask bit seven set.
// RQ20 - Software clears all bits at init before enabling interrupts.
`timescale 1ns/1ps
module icir_regs
	import icir_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic WB_ERR_O,
	input wire logic [7:0] TX_CONTEXT_IRQ,
	input wire logic [3:0] RX_CONTEXT_IRQ,
	output logic TX_SUMMARY_EVENT,
	output logic RX_SUMMARY_EVENT,
	output logic IRQ
);
	logic [7:0] tx_event_reg;
	logic [7:0] tx_mask_reg;
	logic [3:0] rx_event_reg;
	logic [3:0] rx_mask_reg;
	logic [7:0] tx_irq_d_reg;
	logic [3:0] rx_irq_d_reg;
	logic [1:0] main_mask_reg;
	logic global_en_reg;
	logic ack_reg;
	logic err_reg;
	logic [31:0] dat_reg;
	logic req;
	logic wr;
	logic mapped;
	logic [31:0] wdat;
	logic [31:0] rdata;
	logic [7:0] tx_rise;
	logic [3:0] rx_rise;

	assign req = WB_CYC_I && WB_STB_I && !ack_reg && !err_reg;
	assign wr = req && WB_WE_I && mapped;
	assign wdat = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
		{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}} & WB_DAT_I;

	// RQ1 RQ2 RQ8 context edges
	assign tx_rise = TX_CONTEXT_IRQ & ~tx_irq_d_reg;
	assign rx_rise = RX_CONTEXT_IRQ & ~rx_irq_d_reg;

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			tx_irq_d_reg <= ICIR_TX_RESET;
			rx_irq_d_reg <= ICIR_RX_RESET;
		end else begin
			tx_irq_d_reg <= TX_CONTEXT_IRQ;
			rx_irq_d_reg <= RX_CONTEXT_IRQ;
		end
	end

	// Address decode and read mux
	always_comb begin
		mapped = 1'b1;
		rdata = 32'h0000_0000;
		case (WB_ADR_I)
			// RQ6 RQ9 masked view
			ICIR_TX_EVENT_CLEAR: rdata = {24'h000000, tx_event_reg & tx_mask_reg};
			ICIR_TX_EVENT_SET: rdata = {24'h000000, tx_event_reg};
			// RQ14 mask on both
			ICIR_TX_MASK_SET, ICIR_TX_MASK_CLEAR: rdata = {24'h000000, tx_mask_reg};
			// RQ7 RQ10 masked view
			ICIR_RX_EVENT_CLEAR: rdata = {28'h0000000, rx_event_reg & rx_mask_reg};
			ICIR_RX_EVENT_SET: rdata = {28'h0000000, rx_event_reg};
			ICIR_RX_MASK_SET, ICIR_RX_MASK_CLEAR: rdata = {28'h0000000, rx_mask_reg};
			ICIR_MAIN_EVENT: begin
				rdata[ICIR_TX_SUM_BIT] = TX_SUMMARY_EVENT;
				rdata[ICIR_RX_SUM_BIT] = RX_SUMMARY_EVENT;
			end
			ICIR_MAIN_MASK_SET, ICIR_MAIN_MASK_CLEAR: begin
				rdata[ICIR_GLOBAL_EN_BIT] = global_en_reg;
				rdata[ICIR_TX_SUM_BIT] = main_mask_reg[0];
				rdata[ICIR_RX_SUM_BIT] = main_mask_reg[1];
			end
			default: mapped = 1'b0;
		endcase
	end

	// Bus answer one cycle after request
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req && mapped;
			err_reg <= req && !mapped;
			if (req && mapped && !WB_WE_I)
				dat_reg <= rdata;
		end
	end

	assign WB_ACK_O = ack_reg;
	assign WB_ERR_O = err_reg;
	assign WB_DAT_O = dat_reg;

	// RQ3 RQ5 set wins over clear
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			tx_event_reg <= ICIR_TX_RESET;
		end else begin
			tx_event_reg <= (tx_event_reg
				& ~((wr && WB_ADR_I == ICIR_TX_EVENT_CLEAR) ? wdat[7:0] : 8'h00))
				| tx_rise
				| ((wr && WB_ADR_I == ICIR_TX_EVENT_SET) ? wdat[7:0] : 8'h00);
		end
	end

	// RQ4 RQ5 set wins over clear
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			rx_event_reg <= ICIR_RX_RESET;
		end else begin
			rx_event_reg <= (rx_event_reg
				& ~((wr && WB_ADR_I == ICIR_RX_EVENT_CLEAR) ? wdat[3:0] : 4'h0))
				| rx_rise
				| ((wr && WB_ADR_I == ICIR_RX_EVENT_SET) ? wdat[3:0] : 4'h0);
		end
	end

	// RQ13 RQ15 mask set and clear
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			tx_mask_reg <= ICIR_TX_RESET;
			rx_mask_reg <= ICIR_RX_RESET;
		end else if (wr) begin
			if (WB_ADR_I == ICIR_TX_MASK_SET)
				tx_mask_reg <= tx_mask_reg | wdat[7:0];
			if (WB_ADR_I == ICIR_TX_MASK_CLEAR)
				tx_mask_reg <= tx_mask_reg & ~wdat[7:0];
			if (WB_ADR_I == ICIR_RX_MASK_SET)
				rx_mask_reg <= rx_mask_reg | wdat[3:0];
			if (WB_ADR_I == ICIR_RX_MASK_CLEAR)
				rx_mask_reg <= rx_mask_reg & ~wdat[3:0];
		end
	end

	// Main mask bits and global enable
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			main_mask_reg <= 2'h0;
			global_en_reg <= 1'b0;
		end else if (wr && WB_ADR_I == ICIR_MAIN_MASK_SET) begin
			main_mask_reg <= main_mask_reg
				| {wdat[ICIR_RX_SUM_BIT], wdat[ICIR_TX_SUM_BIT]};
			global_en_reg <= global_en_reg | wdat[ICIR_GLOBAL_EN_BIT];
		end else if (wr && WB_ADR_I == ICIR_MAIN_MASK_CLEAR) begin
			main_mask_reg <= main_mask_reg
				& ~{wdat[ICIR_RX_SUM_BIT], wdat[ICIR_TX_SUM_BIT]};
			global_en_reg <= global_en_reg & ~wdat[ICIR_GLOBAL_EN_BIT];
		end
	end

	// RQ11 transmit summary
	assign TX_SUMMARY_EVENT = |(tx_event_reg & tx_mask_reg);
	// RQ12 receive summary
	assign RX_SUMMARY_EVENT = |(rx_event_reg & rx_mask_reg);

	// RQ17 RQ18 RQ19 gated interrupt
	assign IRQ = global_en_reg && ((TX_SUMMARY_EVENT && main_mask_reg[0])
		|| (RX_SUMMARY_EVENT && main_mask_reg[1]));
endmodule : icir_regs

// file: tb/icir_monitor.sv
// Assertion checker of the context interrupt register block.
// Bound to the top module and sees only its ports.
`timescale 1ns/1ps
module icir_monitor
	import icir_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic WB_ERR_O,
	input wire logic TX_SUMMARY_EVENT,
	input wire logic RX_SUMMARY_EVENT,
	input wire logic IRQ
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	wire wr_clr = WB_CYC_I && WB_WE_I && WB_ADR_I[2];
	wire tx_a = WB_ADR_I[7:4] == 4'h9;
	sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O; endsequence
	sequence s_rd(a); WB_ACK_O && !WB_WE_I && WB_ADR_I == a; endsequence
	AST_ANSWER: assert property (s_req |=> (WB_ACK_O ^ WB_ERR_O) ##1 !WB_ACK_O)
		else $error("bus answer wrong");
	AST_TXHOLD: assert property (TX_SUMMARY_EVENT && !(wr_clr && tx_a) |=>
		TX_SUMMARY_EVENT) else $error("tx event lost");
	AST_RXHOLD: assert property (RX_SUMMARY_EVENT && !(wr_clr && !tx_a) |=>
		RX_SUMMARY_EVENT) else $error("rx event lost");
	AST_IRQSRC: assert property (IRQ |->
		TX_SUMMARY_EVENT || RX_SUMMARY_EVENT) else $error("irq without event");
	AST_TXRD: assert property (s_rd(ICIR_TX_EVENT_CLEAR) |->
		WB_DAT_O[31:8] == 24'h000000 && (WB_DAT_O == 32'h00000000
		|| TX_SUMMARY_EVENT)) else $error("tx read bad");
	AST_RXRD: assert property (s_rd(ICIR_RX_EVENT_CLEAR) |->
		WB_DAT_O[31:4] == 28'h0000000 && (WB_DAT_O == 32'h00000000
		|| RX_SUMMARY_EVENT)) else $error("rx read bad");
	AST_TXMASK: assert property (s_rd(ICIR_TX_MASK_CLEAR) |->
		WB_DAT_O[31:8] == 0) else $error("tx mask bad");
	AST_TXRAW: assert property (s_rd(ICIR_TX_EVENT_SET) |->
		WB_DAT_O[31:8] == 0) else $error("tx raw bad");
endmodule : icir_monitor
bind icir_regs icir_monitor u_mon(.CLOCK, .RESETN, .WB_CYC_I, .WB_STB_I,
	.WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .WB_ERR_O, .TX_SUMMARY_EVENT,
	.RX_SUMMARY_EVENT, .IRQ);

// file: tb/icir_regs_test.sv
// Self-checking bench of the context interrupt register block.
// Assumes each Wishbone request is answered by ack or err.
`timescale 1ns/1ps
module icir_regs_test
	import icir_pkg::*;
;
	logic clock = 0, resetn = 0, cyc = 0, stb = 0, we = 0, ack, err, ts, rs, irq;
	logic [7:0] adr = '0, tx_irq = '0;
	logic [3:0] rx_irq = '0;
	logic [31:0] wdat = '0, rdat;
	logic [32:0] exp_q[$], cur;
	int num_errors = 0, n_tests = 0, seed = 32'h567A;
	always #50 clock = ~clock;
	icir_regs dut(.CLOCK(clock), .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err), .TX_CONTEXT_IRQ(tx_irq),
		.RX_CONTEXT_IRQ(rx_irq), .TX_SUMMARY_EVENT(ts), .RX_SUMMARY_EVENT(rs),
		.IRQ(irq));
	task automatic conclude;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude
	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		{cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
		do @(negedge clock); while (!(ack || err));
		@(posedge clock);
		{cyc, stb} <= 2'h0;
	endtask : bus
	task automatic rd(logic [7:0] a, logic [32:0] e);
		exp_q.push_back(e);
		bus(1'h0, a, '0);
	endtask : rd
	task automatic lv(logic s, logic i, bit rx);
		@(negedge clock);
		cmp("summary", {31'h0, s}, {31'h0, rx ? rs : ts});
		cmp("irq", {31'h0, i}, {31'h0, irq});
	endtask : lv
	always @(negedge clock) begin
		if ((ack && !we) || err) begin
			cur = exp_q.pop_front();
			cmp("err", {31'h0, cur[32]}, {31'h0, err});
			if (!cur[32]) cmp("read", cur[31:0], rdat);
		end
	end
	task automatic ctx(bit rx);
		logic [7:0] b, m, r;
		b = rx ? ICIR_RX_EVENT_SET : ICIR_TX_EVENT_SET;
		m = rx ? 8'h0F : 8'hFF;
		r = (8'($random(seed)) | 8'h01) & m;
		@(posedge clock);
		{tx_irq, rx_irq} <= rx ? {8'h0, r[3:0]} : {r, 4'h0};
		@(posedge clock);
		{tx_irq, rx_irq} <= '0;
		rd(b, {25'h0, r});
		rd(b + 8'h04, '0);
		lv(1'h0, 1'h0, rx);
		bus(1'h1, b + 8'h08, '1);
		rd(b + 8'h0C, {25'h0, m});
		rd(b + 8'h04, {25'h0, r});
		lv(1'h1, 1'h1, rx);
		bus(1'h1, b + 8'h04, '0);
		bus(1'h1, b, '1);
		rd(b, {25'h0, m});
		bus(1'h1, ICIR_MAIN_MASK_CLEAR, 32'h80000000);
		lv(1'h1, 1'h0, rx);
		bus(1'h1, ICIR_MAIN_MASK_SET, 32'h80000000);
		bus(1'h1, b + 8'h04, '1);
		rd(b, '0);
		bus(1'h1, b + 8'h0C, '1);
		rd(b + 8'h08, '0);
	endtask : ctx
	initial begin
		repeat (5) @(posedge clock);
		resetn <= 1'h1;
		for (int i = 0; i < 4; i++) bus(1'h1, 8'h94 + 8'(8 * i), '1);
		bus(1'h1, ICIR_MAIN_MASK_SET, 32'h800000C0);
		ctx(1'b0);
		ctx(1'b1);
		rd(8'h00, 33'h100000000);
		conclude();
	end
	initial begin
		repeat (3000) @(posedge clock);
		num_errors++;
		conclude();
	end
endmodule : icir_regs_test
